/* logic/rgch_cmd_handler.sv */
// command handler: gpio output, channel, tx power, radio state and rssi commands
`timescale 1ns/10ps
`include "rgch_regs.svh"
module rgch_cmd_handler
  import rgch_pkg::*;
(
  input  wire logic         clock_i,
  input  wire logic         rst_b_i,
  input  wire logic         ce_i,
  input  wire logic         rx_valid_i,
  input  wire logic [7:0]   rx_byte_i,
  input  wire logic [7:0]   out_default_i,
  input  wire logic [7:0]   out_enable_cfg_i,
  input  wire logic [7:0]   analog_cfg_i,
  input  wire logic [1:0]   chan_stored_i,
  input  wire logic [7:0]   power_stored_i,
  input  wire logic         end_node_i,
  input  wire logic         tx_pending_i,
  input  wire logic         radio_fault_i,
  input  wire logic [7:0]   ambient_level_i,
  output logic              rsp_valid_o,
  output rgch_rsp_type      rsp_o,
  output logic [7:0]        gpio_out_o,
  output logic [7:0]        gpio_oe_o,
  output logic [7:0]        transmit_power_setting_o,
  output logic [7:0]        radio_state_code_o,
  output logic              radio_power_o,
  output logic              rx_enable_o,
  output logic              tx_enable_o,
  output logic              power_down_state_o
);
  logic                cmd_valid;
  rgch_cmd_type        cmd;
  logic [1:0]          nparam;
  logic [7:0]          out_lvl_r, out_lvl_nxt;
  logic [7:0]          pwr_r, pwr_nxt;
  rgch_radio_type      base_r, base_nxt;
  logic                loaded_r, loaded_nxt;
  logic                rsp_v_r, rsp_v_nxt;
  rgch_rsp_type        rsp_r, rsp_nxt;
  rgch_radio_type      eff_state;
  logic [7:0]          amb_s1_r, amb_s2_r;
  logic [1:0]          tx_s_r, flt_s_r;
  logic                txp, flt;

  // pin inputs pass two flip-flops
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      amb_s1_r <= 8'h00;
      amb_s2_r <= 8'h00;
      tx_s_r   <= 2'h0;
      flt_s_r  <= 2'h0;
    end
    else if (ce_i)
    begin
      amb_s1_r <= ambient_level_i;
      amb_s2_r <= amb_s1_r;
      tx_s_r   <= {tx_s_r[0], tx_pending_i};
      flt_s_r  <= {flt_s_r[0], radio_fault_i};
    end
  end
  assign txp = tx_s_r[1];
  assign flt = flt_s_r[1];

  rgch_frame_rx u_rx (
    .clock_i      (clock_i),
    .rst_b_i      (rst_b_i),
    .ce_i         (ce_i),
    .rx_valid_i   (rx_valid_i),
    .rx_byte_i    (rx_byte_i),
    .cmd_valid_o  (cmd_valid),
    .cmd_o        (cmd),
    .cmd_nparam_o (nparam)
  );

  function automatic logic [7:0] state_code(input rgch_radio_type s);
    unique case (s)
      RGCH_RADIO_SLEEP: state_code = `RGCH_RS_SLEEP;
      RGCH_RADIO_IDLE:  state_code = `RGCH_RS_IDLE;
      RGCH_RADIO_RX_ON: state_code = `RGCH_RS_RX_ON;
      RGCH_RADIO_TX_ON: state_code = `RGCH_RS_TX_ON;
      default:          state_code = `RGCH_RS_UNKNOWN;
    endcase
  endfunction

  function automatic logic out_ok(input logic [7:0] gpio);
    out_ok = (gpio < 8'(`RGCH_GPIO_COUNT)) && out_enable_cfg_i[gpio[2:0]]
             && !analog_cfg_i[gpio[2:0]];
  endfunction

  // transmit overrides any awake base state; sleep and power down hold off
  always_comb
  begin
    if (flt)
      eff_state = RGCH_RADIO_UNKNOWN;
    else if (txp && (base_r == RGCH_RADIO_IDLE || base_r == RGCH_RADIO_RX_ON))
      eff_state = RGCH_RADIO_TX_ON;
    else
      eff_state = base_r;
  end

  always_comb
  begin
    out_lvl_nxt = out_lvl_r;
    pwr_nxt     = pwr_r;
    base_nxt    = base_r;
    loaded_nxt  = 1'b1;
    rsp_v_nxt   = 1'b0;
    rsp_nxt     = rsp_r;
    if (!loaded_r)
    begin
      out_lvl_nxt = out_default_i;
      pwr_nxt     = power_stored_i;
    end
    else if (cmd_valid)
    begin
      rsp_v_nxt    = 1'b1;
      rsp_nxt.code = cmd.code;
      rsp_nxt.p1   = `RGCH_STATUS_ERR;
      unique case (cmd.code)
        `RGCH_CMD_WR_OUT:
          if (nparam == 2'd3 && cmd.p1 == `RGCH_PARAM_ZERO && out_ok(cmd.p2)
              && (cmd.p3 == `RGCH_LEVEL_HIGH || cmd.p3 == `RGCH_LEVEL_LOW))
          begin
            out_lvl_nxt[cmd.p2[2:0]] = cmd.p3[0];
            rsp_nxt.p1               = `RGCH_STATUS_OK;
          end
        `RGCH_CMD_RD_CHAN:
          rsp_nxt.p1 = {6'h00, chan_stored_i};
        `RGCH_CMD_RD_PWR:
          rsp_nxt.p1 = pwr_r;
        `RGCH_CMD_WR_PWR:
          if (nparam == 2'd1)
          begin
            pwr_nxt    = cmd.p1;
            rsp_nxt.p1 = `RGCH_STATUS_OK;
          end
        `RGCH_CMD_RD_STATE:
          rsp_nxt.p1 = state_code(eff_state);
        `RGCH_CMD_WR_STATE:
          if (nparam == 2'd1)
          begin
            rsp_nxt.p1 = `RGCH_STATUS_OK;
            unique case (cmd.p1)
              `RGCH_WS_AWAKE: base_nxt = RGCH_RADIO_RX_ON;
              `RGCH_WS_RX_ON: base_nxt = RGCH_RADIO_RX_ON;
              `RGCH_WS_SLEEP: if (end_node_i) base_nxt = RGCH_RADIO_SLEEP;
                              else rsp_nxt.p1 = `RGCH_STATUS_ERR;
              `RGCH_WS_IDLE:  if (end_node_i) base_nxt = RGCH_RADIO_IDLE;
                              else rsp_nxt.p1 = `RGCH_STATUS_ERR;
              `RGCH_WS_PDN:   if (end_node_i) base_nxt = RGCH_RADIO_PDN;
                              else rsp_nxt.p1 = `RGCH_STATUS_ERR;
              default:        rsp_nxt.p1 = `RGCH_STATUS_ERR;
            endcase
          end
        `RGCH_CMD_RD_RSSI:
          rsp_nxt.p1 = amb_s2_r;
        default:
        begin
          // unknown codes: no answer, last response keeps standing
          rsp_v_nxt = 1'b0;
          rsp_nxt   = rsp_r;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      out_lvl_r <= 8'h00;
      pwr_r     <= 8'h00;
      base_r    <= RGCH_RADIO_RX_ON;
      loaded_r  <= 1'b0;
      rsp_v_r   <= 1'b0;
      rsp_r     <= '0;
    end
    else if (ce_i)
    begin
      out_lvl_r <= out_lvl_nxt;
      pwr_r     <= pwr_nxt;
      base_r    <= base_nxt;
      loaded_r  <= loaded_nxt;
      rsp_v_r   <= rsp_v_nxt;
      rsp_r     <= rsp_nxt;
    end
  end

  assign rsp_valid_o              = rsp_v_r & ce_i;
  assign rsp_o                    = rsp_r;
  assign gpio_out_o               = out_lvl_r & out_enable_cfg_i;
  assign gpio_oe_o                = out_enable_cfg_i & ~analog_cfg_i;
  assign transmit_power_setting_o = pwr_r;
  assign radio_state_code_o       = state_code(eff_state);
  assign radio_power_o            = !(base_r == RGCH_RADIO_SLEEP || base_r == RGCH_RADIO_PDN);
  assign rx_enable_o              = (eff_state == RGCH_RADIO_RX_ON);
  assign tx_enable_o              = (eff_state == RGCH_RADIO_TX_ON);
  assign power_down_state_o       = (base_r == RGCH_RADIO_PDN);

  wire [7:0] st_code_now = state_code(eff_state);

  wr_state_role_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && cmd_valid && loaded_r && cmd.code == `RGCH_CMD_WR_STATE && !end_node_i
    |=> base_r != RGCH_RADIO_SLEEP && base_r != RGCH_RADIO_IDLE && base_r != RGCH_RADIO_PDN)
    else $error("non end node left the awake states");
  bad_state_err_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && cmd_valid && loaded_r && cmd.code == `RGCH_CMD_WR_STATE && cmd.p1 > `RGCH_WS_PDN
    |=> rsp_r.p1 == `RGCH_STATUS_ERR && $stable(base_r))
    else $error("bad state code not refused");
  wr_out_level_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && cmd_valid && loaded_r && cmd.code == `RGCH_CMD_WR_OUT && nparam == 2'd3
    && cmd.p1 == 8'h00 && out_ok(cmd.p2) && cmd.p3 == 8'h01
    |=> out_lvl_r[$past(cmd.p2[2:0])] && rsp_r.p1 == `RGCH_STATUS_OK)
    else $error("output write did not drive high");
  wr_out_refuse_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && cmd_valid && loaded_r && cmd.code == `RGCH_CMD_WR_OUT && !out_ok(cmd.p2)
    |=> $stable(out_lvl_r) && rsp_r.p1 == `RGCH_STATUS_ERR)
    else $error("write to non output line accepted");
  rd_power_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && cmd_valid && loaded_r && cmd.code == `RGCH_CMD_RD_PWR
    |=> rsp_v_r && rsp_r.p1 == $past(pwr_r))
    else $error("power read mismatch");
  wr_power_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && cmd_valid && loaded_r && cmd.code == `RGCH_CMD_WR_PWR && nparam == 2'd1
    |=> pwr_r == $past(cmd.p1))
    else $error("power write not stored");
  rd_chan_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && cmd_valid && loaded_r && cmd.code == `RGCH_CMD_RD_CHAN
    |=> rsp_v_r && rsp_r.p1 == {6'h00, $past(chan_stored_i)} && rsp_r.p1 <= 8'h03)
    else $error("channel answer wrong");
  tx_auto_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    txp && !flt && base_r == RGCH_RADIO_IDLE |-> tx_enable_o && !rx_enable_o)
    else $error("pending data did not force transmit");
  state_code_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && cmd_valid && loaded_r && cmd.code == `RGCH_CMD_RD_STATE
    |=> rsp_v_r && rsp_r.p1 == $past(st_code_now) && rsp_r.p1 <= `RGCH_RS_TX_ON)
    else $error("state read answer wrong");
  sleep_off_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    base_r == RGCH_RADIO_SLEEP |-> !radio_power_o && !tx_enable_o)
    else $error("radio powered in sleep");

  cv_wr_out_c: cover property (@(posedge clock_i) cmd_valid && cmd.code == `RGCH_CMD_WR_OUT);
  cv_sleep_c:  cover property (@(posedge clock_i) base_r == RGCH_RADIO_SLEEP);
  cv_tx_c:     cover property (@(posedge clock_i) tx_enable_o);
  cv_rssi_c:   cover property (@(posedge clock_i) cmd_valid && cmd.code == `RGCH_CMD_RD_RSSI);
endmodule

/* logic/rgch_regs.svh */
// frame bytes, command codes, state codes and status values for the command handler
`ifndef RGCH_REGS_SVH
`define RGCH_REGS_SVH
`define RGCH_START_BYTE   8'h3C
`define RGCH_END_BYTE     8'h3E
`define RGCH_CMD_WR_OUT   8'h28
`define RGCH_CMD_RD_CHAN  8'h29
`define RGCH_CMD_RD_PWR   8'h2B
`define RGCH_CMD_WR_PWR   8'h2C
`define RGCH_CMD_RD_STATE 8'h2D
`define RGCH_CMD_WR_STATE 8'h2E
`define RGCH_CMD_RD_RSSI  8'h2F
`define RGCH_PARAM_ZERO   8'h00
`define RGCH_STATUS_OK    8'h00
`define RGCH_STATUS_ERR   8'h01
`define RGCH_LEVEL_HIGH   8'h01
`define RGCH_LEVEL_LOW    8'h00
`define RGCH_RS_UNKNOWN   8'h00
`define RGCH_RS_SLEEP     8'h01
`define RGCH_RS_IDLE      8'h02
`define RGCH_RS_RX_ON     8'h03
`define RGCH_RS_TX_ON     8'h04
`define RGCH_WS_AWAKE     8'h00
`define RGCH_WS_SLEEP     8'h01
`define RGCH_WS_IDLE      8'h02
`define RGCH_WS_RX_ON     8'h03
`define RGCH_WS_PDN       8'h04
`define RGCH_RS_PDN_CODE  8'h00
`define RGCH_GPIO_COUNT   8
`define RGCH_MAX_PARAMS   3
`endif

/* logic/rgch_pkg.sv */
// types shared by the command handler modules
package rgch_pkg;
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p3;
  } rgch_cmd_type;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] p1;
  } rgch_rsp_type;

  typedef enum logic [2:0] {
    RGCH_RADIO_UNKNOWN,
    RGCH_RADIO_SLEEP,
    RGCH_RADIO_IDLE,
    RGCH_RADIO_RX_ON,
    RGCH_RADIO_TX_ON,
    RGCH_RADIO_PDN
  } rgch_radio_type;
endpackage

/* logic/rgch_frame_rx.sv */
// byte-stream deframer: start, command code, up to three params, end
`timescale 1ns/10ps
`include "rgch_regs.svh"
module rgch_frame_rx
  import rgch_pkg::*;
(
  input  wire logic         clock_i,
  input  wire logic         rst_b_i,
  input  wire logic         ce_i,
  input  wire logic         rx_valid_i,
  input  wire logic [7:0]   rx_byte_i,
  output logic              cmd_valid_o,
  output rgch_cmd_type      cmd_o,
  output logic [1:0]        cmd_nparam_o
);
  typedef enum logic [1:0] {RGCH_FR_HUNT, RGCH_FR_CODE, RGCH_FR_BODY} rgch_fr_type;
  rgch_fr_type  st_r, st_nxt;
  rgch_cmd_type cmd_r, cmd_nxt;
  logic [1:0]   cnt_r, cnt_nxt;
  logic         done_r, done_nxt;

  always_comb
  begin
    st_nxt   = st_r;
    cmd_nxt  = cmd_r;
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    if (rx_valid_i)
    begin
      unique case (st_r)
        RGCH_FR_HUNT:
          if (rx_byte_i == `RGCH_START_BYTE)
          begin
            st_nxt  = RGCH_FR_CODE;
            cnt_nxt = 2'd0;
            cmd_nxt = '0;
          end
        RGCH_FR_CODE:
        begin
          cmd_nxt.code = rx_byte_i;
          st_nxt       = RGCH_FR_BODY;
        end
        RGCH_FR_BODY:
          if (rx_byte_i == `RGCH_END_BYTE)
          begin
            done_nxt = 1'b1;
            st_nxt   = RGCH_FR_HUNT;
          end
          else if (cnt_r == 2'd3)
            st_nxt = RGCH_FR_HUNT;
          else
          begin
            unique case (cnt_r)
              2'd0:    cmd_nxt.p1 = rx_byte_i;
              2'd1:    cmd_nxt.p2 = rx_byte_i;
              default: cmd_nxt.p3 = rx_byte_i;
            endcase
            cnt_nxt = cnt_r + 2'd1;
          end
        default: st_nxt = RGCH_FR_HUNT;
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      st_r   <= RGCH_FR_HUNT;
      cmd_r  <= '0;
      cnt_r  <= 2'd0;
      done_r <= 1'b0;
    end
    else if (ce_i)
    begin
      st_r   <= st_nxt;
      cmd_r  <= cmd_nxt;
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign cmd_valid_o  = done_r & ce_i;
  assign cmd_o        = cmd_r;
  assign cmd_nparam_o = cnt_r;
endmodule

/* verif/rgch_host_model.sv */
// host model that sends command frames and collects responses
`timescale 1ns/10ps
`include "rgch_regs.svh"
module rgch_host_model
  import rgch_pkg::*;
(
  input  wire logic         clock_i,
  input  wire logic         rsp_valid_i,
  input  wire rgch_rsp_type rsp_i,
  output logic              rx_valid_o,
  output logic [7:0]        rx_byte_o
);
  initial
  begin
    rx_valid_o = 1'b0;
    rx_byte_o  = 8'h00;
  end

  task automatic put(input logic [7:0] b);
    @(posedge clock_i);
    #1;
    rx_valid_o = 1'b1;
    rx_byte_o  = b;
  endtask

  // params packed p1,p2,p3 from the top byte down
  task automatic cmd(input logic [7:0] code, input int n, input logic [23:0] pk,
                     output logic ok, output rgch_rsp_type rsp);
    int i;
    put(`RGCH_START_BYTE);
    put(code);
    for (i = 0; i < n; i++)
      put(pk[23-8*i -: 8]);
    put(`RGCH_END_BYTE);
    @(posedge clock_i);
    #1;
    rx_valid_o = 1'b0;
    ok         = 1'b0;
    // idle byte lane toggles so no stale value passes for data
    for (i = 0; i < 8 && !ok; i++)
    begin
      rx_byte_o = ~rx_byte_o;
      @(posedge clock_i);
      #1;
      if (rsp_valid_i === 1'b1)
      begin
        ok  = 1'b1;
        rsp = rsp_i;
      end
    end
  endtask
endmodule

/* verif/rgch_cmd_handler_bench.sv */
// bench for the command handler driven by the host model
`timescale 1ns/10ps
`include "rgch_regs.svh"
module rgch_cmd_handler_bench
  import rgch_pkg::*;
;
  logic         clock_i, rst_b, rx_valid, end_node, tx_pend, fault, rsp_valid;
  logic         radio_pwr, rx_en, tx_en, power_down_state, ce;
  logic [7:0]   rx_byte, gpio_out, gpio_oe, pwr, state, ambient, pwr_st;
  logic [1:0]   chan;
  rgch_rsp_type rsp;
  int           failures = 0;
  int           cmp_count = 0;

  rgch_host_model u_host (.clock_i(clock_i), .rsp_valid_i(rsp_valid), .rsp_i(rsp),
    .rx_valid_o(rx_valid), .rx_byte_o(rx_byte));

  rgch_cmd_handler u_dut (.clock_i(clock_i), .rst_b_i(rst_b), .ce_i(ce),
    .rx_valid_i(rx_valid), .rx_byte_i(rx_byte), .out_default_i(8'hA5),
    .out_enable_cfg_i(8'h0F), .analog_cfg_i(8'h18), .chan_stored_i(chan),
    .power_stored_i(pwr_st), .end_node_i(end_node), .tx_pending_i(tx_pend),
    .radio_fault_i(fault), .ambient_level_i(ambient), .rsp_valid_o(rsp_valid),
    .rsp_o(rsp), .gpio_out_o(gpio_out), .gpio_oe_o(gpio_oe),
    .transmit_power_setting_o(pwr), .radio_state_code_o(state),
    .radio_power_o(radio_pwr), .rx_enable_o(rx_en), .tx_enable_o(tx_en),
    .power_down_state_o(power_down_state));

  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic do_reset();
    rst_b = 1'b0;
    wt(2);
    rst_b = 1'b1;
    wt(2);
  endtask

  task automatic do_cmd(input logic [7:0] c, input int n, input logic [23:0] pk,
                        input logic [7:0] exp);
    logic         ok;
    rgch_rsp_type r;
    u_host.cmd(c, n, pk, ok, r);
    chk8({7'h0, ok}, 8'h01);
    chk8(r.code, c);
    chk8(r.p1, exp);
  endtask

  task automatic t_reset_vals();
    chk8(state, `RGCH_RS_RX_ON);
    chk8(pwr, 8'h3A);
    chk8(gpio_out, 8'h05);
    chk8(gpio_oe, 8'h07);
    chk8({7'h0, radio_pwr}, 8'h01);
  endtask

  task automatic t_write_out();
    logic [23:0] bad [4] = '{24'h00_0301, 24'h00_0601, 24'h01_0101, 24'h00_0102};
    do_cmd(`RGCH_CMD_WR_OUT, 3, 24'h00_0000, `RGCH_STATUS_OK);
    chk8(gpio_out, 8'h04);
    do_cmd(`RGCH_CMD_WR_OUT, 3, 24'h00_0101, `RGCH_STATUS_OK);
    chk8(gpio_out, 8'h06);
    for (int i = 0; i < 4; i++)
    begin
      do_cmd(`RGCH_CMD_WR_OUT, 3, bad[i], `RGCH_STATUS_ERR);
      chk8(gpio_out, 8'h06);
    end
    do_cmd(`RGCH_CMD_WR_OUT, 2, 24'h00_0100, `RGCH_STATUS_ERR);
  endtask

  task automatic t_channel();
    for (int c = 0; c < 4; c++)
    begin
      chan = c[1:0];
      do_cmd(`RGCH_CMD_RD_CHAN, 0, 24'h0, 8'(c));
    end
  endtask

  task automatic t_power();
    do_cmd(`RGCH_CMD_WR_PWR, 1, 24'hC5_0000, `RGCH_STATUS_OK);
    chk8(pwr, 8'hC5);
    do_cmd(`RGCH_CMD_RD_PWR, 0, 24'h0, 8'hC5);
    do_reset();
    do_cmd(`RGCH_CMD_RD_PWR, 0, 24'h0, 8'h3A);
    chk8(gpio_out, 8'h05);
  endtask

  task automatic set_state(input logic [7:0] c, input logic [7:0] st, input logic [7:0] exp);
    do_cmd(`RGCH_CMD_WR_STATE, 1, {c, 16'h0}, st);
    chk8(state, exp);
  endtask

  task automatic t_state();
    end_node = 1'b0;
    set_state(`RGCH_WS_SLEEP, `RGCH_STATUS_ERR, `RGCH_RS_RX_ON);
    set_state(`RGCH_WS_IDLE, `RGCH_STATUS_ERR, `RGCH_RS_RX_ON);
    set_state(`RGCH_WS_PDN, `RGCH_STATUS_ERR, `RGCH_RS_RX_ON);
    end_node = 1'b1;
    set_state(`RGCH_WS_IDLE, `RGCH_STATUS_OK, `RGCH_RS_IDLE);
    chk8({7'h0, rx_en}, 8'h00);
    tx_pend = 1'b1;
    wt(4);
    chk8({7'h0, tx_en}, 8'h01);
    do_cmd(`RGCH_CMD_RD_STATE, 0, 24'h0, `RGCH_RS_TX_ON);
    tx_pend = 1'b0;
    wt(4);
    chk8(state, `RGCH_RS_IDLE);
    set_state(`RGCH_WS_SLEEP, `RGCH_STATUS_OK, `RGCH_RS_SLEEP);
    tx_pend = 1'b1;
    wt(4);
    chk8({6'h0, radio_pwr, tx_en}, 8'h00);
    tx_pend = 1'b0;
    set_state(`RGCH_WS_RX_ON, `RGCH_STATUS_OK, `RGCH_RS_RX_ON);
    chk8({7'h0, rx_en}, 8'h01);
    set_state(`RGCH_WS_PDN, `RGCH_STATUS_OK, `RGCH_RS_PDN_CODE);
    chk8({7'h0, power_down_state}, 8'h01);
    set_state(`RGCH_WS_AWAKE, `RGCH_STATUS_OK, `RGCH_RS_RX_ON);
    set_state(8'h05, `RGCH_STATUS_ERR, `RGCH_RS_RX_ON);
    fault = 1'b1;
    wt(4);
    do_cmd(`RGCH_CMD_RD_STATE, 0, 24'h0, `RGCH_RS_UNKNOWN);
    fault = 1'b0;
    wt(4);
  endtask

  task automatic t_rssi();
    // reading taken only while receive is on
    chk8(state, `RGCH_RS_RX_ON);
    ambient = 8'hB0;
    wt(4);
    do_cmd(`RGCH_CMD_RD_RSSI, 0, 24'h0, 8'hB0);
    ambient = 8'h7F;
    wt(4);
    do_cmd(`RGCH_CMD_RD_RSSI, 0, 24'h0, 8'h7F);
  endtask

  task automatic t_unknown();
    logic         ok;
    rgch_rsp_type r;
    u_host.cmd(8'h30, 0, 24'h0, ok, r);
    chk8({7'h0, ok}, 8'h00);
    chk8(rsp.code, `RGCH_CMD_RD_RSSI);
    chk8(rsp.p1, 8'h7F);
  endtask

  task automatic t_clock_enable();
    ce      = 1'b0;
    tx_pend = 1'b1;
    wt(4);
    chk8({7'h0, tx_en}, 8'h00);
    ce = 1'b1;
    wt(4);
    chk8({7'h0, tx_en}, 8'h01);
    tx_pend = 1'b0;
    wt(4);
    chk8(state, `RGCH_RS_RX_ON);
  endtask

  initial
  begin
    rst_b    = 1'b0;
    ce       = 1'b1;
    end_node = 1'b0;
    tx_pend  = 1'b0;
    fault    = 1'b0;
    ambient  = 8'h00;
    pwr_st   = 8'h3A;
    chan     = 2'h0;
    do_reset();
    t_reset_vals();
    t_write_out();
    t_channel();
    t_power();
    t_state();
    t_rssi();
    t_unknown();
    t_clock_enable();
    tally_and_finish();
  end

  initial
  begin
    #200_000;
    failures++;
    tally_and_finish();
  end
endmodule
